/* File: src/ubes_pkg.sv */
package ubes_pkg;

   // ==========================================================
   // Register map
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   localparam logic [3:0]  ADDR_STATUS_TWO = 4'h0;
   localparam logic [3:0]  ADDR_CONTROL    = 4'h1;
   localparam logic [3:0]  ADDR_EVENT      = 4'h2;
   localparam logic [3:0]  ADDR_MASK       = 4'h3;

   // ==========================================================
   // Field positions of serial_status_two
   localparam int BIT_BREAK      = 7;
   localparam int BIT_EDGE       = 6;
   localparam int BIT_RESERVED   = 5;
   localparam int BIT_INVERT     = 4;
   localparam int BIT_IDLE_WAKE  = 3;
   localparam int BIT_LONG_BREAK = 2;
   localparam int BIT_LIN        = 1;
   localparam int BIT_ACTIVE     = 0;

   // Control register fields
   localparam int CTL_NINE_BITS  = 0;
   localparam int CTL_TWO_STOP   = 1;
   localparam int CTL_SEND_BREAK = 2;

   // Event register fields (bits 7 and 6 mirror the two flags above)
   localparam int EVT_FRAMING    = 0;
   localparam int EVT_FULL       = 1;
   localparam int EVT_IDLE       = 2;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [7:0] RESET_MASK    = 8'h00;
   localparam logic       RESET_FLAG    = 1'b0;

   // ==========================================================
   // Frame and timing
   localparam logic [3:0] BASE_BITS        = 4'hA;
   localparam logic [3:0] LIN_EXTRA_BITS   = 4'h1;
   localparam logic [3:0] LONG_EXTRA_BITS  = 4'h3;
   localparam logic [3:0] DATA_BITS_SHORT  = 4'h8;
   localparam int         CYC_W            = 16;
   localparam int         CLOCK_HZ         = 125_000_000;
   localparam int         DEFAULT_BAUD     = 115_200;
   localparam int         DEFAULT_BIT_CLKS = CLOCK_HZ / DEFAULT_BAUD;

   typedef enum {RX_IDLE, RX_START, RX_BITS, RX_BREAK, RX_HOLD} ubes_rx_state_type;

   // Frame length in bits: 10 for 8-bit one-stop, one more each for nine data or two stops
   function automatic logic [3:0] frame_bits(input logic nine, input logic two);
      frame_bits = BASE_BITS + {3'h0, nine} + {3'h0, two};
   endfunction

endpackage

/* File: src/ubes_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ubes_cfg_if;
   logic nine_bits;
   logic two_stop;
   logic long_break;
   modport ctrl (output nine_bits, output two_stop, output long_break);
   modport user (input nine_bits, input two_stop, input long_break);
endinterface
`default_nettype wire

/* File: src/ubes_rx_front.sv */
`timescale 1ns/1ps
`default_nettype none
module ubes_rx_front (
   input  wire logic clock_i,    // Module clock
   input  wire logic rst_n_i,    // Synchronous reset, active low
   input  wire logic ce_i,       // Clock enable
   input  wire logic rxd_i,      // Receive pin, asynchronous
   input  wire logic invert_i,   // Receive inversion
   output logic      level_o,    // Line level after inversion, idle high
   output logic      edge_o      // One-cycle pulse on an active edge
);
   logic sync_a;
   logic sync_b;
   logic next_level;
   logic next_edge;

   // ==========================================================
   // Inversion sits ahead of edge detection, so falling on the
   // inverted level is a rising raw edge when inversion is on
   always_comb begin
      next_level = sync_b ^ invert_i;
      next_edge  = level_o & ~next_level;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sync_a  <= 1'b1;
         sync_b  <= 1'b1;
         level_o <= 1'b1;
         edge_o  <= 1'b0;
      end else if (ce_i) begin
         sync_a  <= rxd_i;
         sync_b  <= sync_a;
         level_o <= next_level;
         edge_o  <= next_edge;
      end
   end
endmodule
`default_nettype wire

/* File: src/ubes_tx_break.sv */
`timescale 1ns/1ps
`default_nettype none
module ubes_tx_break #(
   parameter int BIT_CLKS = ubes_pkg::DEFAULT_BIT_CLKS
) (
   input  wire logic clock_i,     // Module clock
   input  wire logic rst_n_i,     // Synchronous reset, active low
   input  wire logic ce_i,        // Clock enable
   ubes_cfg_if.user  cfg,         // Frame format
   input  wire logic send_i,      // Start one break, pulse
   output logic      txd_o,       // Transmit line, idle high
   output logic      busy_o       // Break in progress
);
   logic [ubes_pkg::CYC_W-1:0] cyc;
   logic [3:0]                 bits;
   logic [ubes_pkg::CYC_W-1:0] next_cyc;
   logic [3:0]                 next_bits;
   logic                       next_busy;
   logic [3:0]                 length;

   // ==========================================================
   always_comb begin
      length    = ubes_pkg::frame_bits(cfg.nine_bits, cfg.two_stop)
                + (cfg.long_break ? ubes_pkg::LONG_EXTRA_BITS : 4'h0);
      next_cyc  = cyc;
      next_bits = bits;
      next_busy = busy_o;
      if (!busy_o) begin
         if (send_i) begin
            next_busy = 1'b1;
            next_cyc  = '0;
            next_bits = 4'h0;
         end
      end else if (cyc == ubes_pkg::CYC_W'(BIT_CLKS - 1)) begin
         next_cyc  = '0;
         next_bits = bits + 4'h1;
         if (bits + 4'h1 == length) begin
            next_busy = 1'b0;
         end
      end else begin
         next_cyc = cyc + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cyc    <= '0;
         bits   <= 4'h0;
         busy_o <= 1'b0;
         txd_o  <= 1'b1;
      end else if (ce_i) begin
         cyc    <= next_cyc;
         bits   <= next_bits;
         busy_o <= next_busy;
         txd_o  <= ~next_busy;
      end
   end
endmodule
`default_nettype wire

/* File: src/ubes_top.sv */
// How it works
// - With LIN detection on, a recognised break sets the break flag in bit 7.
// - Break flag clears only on a written one; a written zero keeps it.
// - Active receive edge sets bit 6: falling normally, rising when inverted.
// - Writing one to bit 6 clears the receive edge flag.
// - Bit 5 is read-only and always reads zero.
// - Bit 4 inverts the whole receive input, every frame element included.
// - In standby, bit 3 decides whether a detected idle sets idle status.
// - Normal transmitted break lasts 10, 11 or 12 bits by frame format.
// - Long break select stretches transmitted break to 13, 14 or 15 bits.
// - Long break select touches only the transmitter, never framing checks.
// - Without LIN detection, break is recognised after 10, 11 or 12 bits.
// - With LIN detection, break threshold rises to 11, 12 or 13 bits.
// - While LIN detection is on, framing error and buffer full never set.
// - Receiver active sets on a valid start bit, clears on idle line.
// - Low stop bit raises framing error together with buffer full.
// - Frame length select set gives nine data bits, cleared gives eight.
`timescale 1ns/1ps
`default_nettype none
module ubes_top #(
   parameter int BIT_CLKS = ubes_pkg::DEFAULT_BIT_CLKS
) (
   input  wire logic                        clock_i,               // Module clock
   input  wire logic                        rst_n_i,               // Synchronous reset, active low
   input  wire logic                        ce_i,                  // Clock enable, freezes all state
   input  wire logic [ubes_pkg::ADDR_W-1:0] addr_i,                // Register address
   input  wire logic [ubes_pkg::DATA_W-1:0] wdata_i,               // Write data
   input  wire logic                        wr_i,                  // Write strobe
   input  wire logic                        rd_i,                  // Read strobe
   output logic      [ubes_pkg::DATA_W-1:0] rdata_o,               // Read data, cycle after strobe
   input  wire logic                        rxd_i,                 // Receive pin
   input  wire logic                        receiver_standby_i,    // Receiver in wake-up standby
   output logic                             txd_o,                 // Transmit pin
   output logic                             receiver_active_flag_o, // Receiver busy
   output logic                             framing_error_flag_o,  // Framing error, pulse
   output logic                             receive_buffer_full_o, // Character received, pulse
   output logic                             idle_detected_o,       // Idle status set, pulse
   output logic                             irq_o                  // Interrupt, level
);
   ubes_cfg_if cfg_bus ();

   logic       rx_level;
   logic       edge_evt;
   logic       tx_busy;
   logic       tx_line;

   // Control state
   logic       break_flag;
   logic       edge_flag;
   logic       receive_invert;
   logic       idle_on_wake_select;
   logic       long_break_select;
   logic       lin_break_detect_enable;
   logic [7:0] control;
   logic [7:0] mask;
   logic       framing_sticky;
   logic       full_sticky;
   logic       idle_sticky;
   logic       send_break;

   logic       next_break_flag;
   logic       next_edge_flag;
   logic       next_receive_invert;
   logic       next_idle_on_wake_select;
   logic       next_long_break_select;
   logic       next_lin_break_detect_enable;
   logic [7:0] next_control;
   logic [7:0] next_mask;
   logic       next_framing_sticky;
   logic       next_full_sticky;
   logic       next_idle_sticky;
   logic       next_send_break;
   logic [7:0] next_rdata;
   logic       next_irq;

   // Receiver state
   ubes_pkg::ubes_rx_state_type rx_state;
   ubes_pkg::ubes_rx_state_type next_rx_state;
   logic [ubes_pkg::CYC_W-1:0]  cyc;
   logic [ubes_pkg::CYC_W-1:0]  next_cyc;
   logic [3:0]                  pos;
   logic [3:0]                  next_pos;
   logic [3:0]                  low_run;
   logic [3:0]                  next_low_run;
   logic                        stop_low;
   logic                        next_stop_low;
   logic                        active;
   logic                        next_active;
   logic                        next_framing;
   logic                        next_full;
   logic                        next_idle;

   // Receiver combinational helpers
   logic       sample;
   logic       line_low;
   logic [3:0] frame_len;
   logic [3:0] data_len;
   logic [3:0] threshold;
   logic [3:0] run_inc;
   logic       char_done;
   logic       break_seen;
   logic       idle_seen;

   // Register helpers
   logic [7:0] status_view;
   logic [7:0] event_view;
   logic       wr_status;
   logic       wr_event;

   assign cfg_bus.nine_bits  = control[ubes_pkg::CTL_NINE_BITS];
   assign cfg_bus.two_stop   = control[ubes_pkg::CTL_TWO_STOP];
   assign cfg_bus.long_break = long_break_select;

   ubes_rx_front u_front (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .ce_i     (ce_i),
      .rxd_i    (rxd_i),
      .invert_i (receive_invert),
      .level_o  (rx_level),
      .edge_o   (edge_evt)
   );

   ubes_tx_break #(.BIT_CLKS(BIT_CLKS)) u_tx (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .ce_i    (ce_i),
      .cfg     (cfg_bus),
      .send_i  (send_break),
      .txd_o   (tx_line),
      .busy_o  (tx_busy)
   );

   // ==========================================================
   // Receiver: samples at mid-bit and counts an unbroken low run
   // from the start bit; the long break select never enters here
   always_comb begin
      frame_len  = ubes_pkg::frame_bits(cfg_bus.nine_bits, cfg_bus.two_stop);
      data_len   = ubes_pkg::DATA_BITS_SHORT + {3'h0, cfg_bus.nine_bits};
      threshold  = frame_len + (lin_break_detect_enable ? ubes_pkg::LIN_EXTRA_BITS : 4'h0);
      line_low   = ~rx_level;
      sample     = (cyc == ubes_pkg::CYC_W'(BIT_CLKS - 1));
      run_inc    = (low_run == 4'hF) ? low_run : low_run + 4'h1;
      next_rx_state = rx_state;
      next_cyc      = cyc + 1'b1;
      next_pos      = pos;
      next_low_run  = low_run;
      next_stop_low = stop_low;
      next_active   = active;
      char_done     = 1'b0;
      break_seen    = 1'b0;
      idle_seen     = 1'b0;
      case (rx_state)
         ubes_pkg::RX_IDLE: begin
            if (line_low) begin
               next_rx_state = ubes_pkg::RX_START;
               next_cyc      = '0;
            end else if (!active) begin
               next_cyc = '0;
            end else if (sample) begin
               next_cyc = '0;
               next_pos = pos + 4'h1;
               if (pos + 4'h1 == frame_len) begin
                  idle_seen   = 1'b1;
                  next_active = 1'b0;
               end
            end
         end
         ubes_pkg::RX_START: begin
            if (cyc == ubes_pkg::CYC_W'(BIT_CLKS / 2)) begin
               next_cyc = '0;
               next_pos = 4'h0;
               if (line_low) begin
                  next_rx_state = ubes_pkg::RX_BITS;
                  next_active   = 1'b1;
                  next_low_run  = 4'h1;
                  next_stop_low = 1'b0;
               end else begin
                  next_rx_state = ubes_pkg::RX_IDLE;
               end
            end
         end
         ubes_pkg::RX_BITS: begin
            if (sample) begin
               next_cyc      = '0;
               next_pos      = pos + 4'h1;
               next_low_run  = line_low ? run_inc : 4'h0;
               next_stop_low = stop_low | (line_low & (pos + 4'h1 > data_len));
               if (pos + 4'h1 == frame_len - 4'h1) begin
                  char_done = 1'b1;
               end
               if (line_low && run_inc == threshold) begin
                  break_seen    = 1'b1;
                  next_rx_state = ubes_pkg::RX_HOLD;
               end else if (pos + 4'h1 == frame_len - 4'h1) begin
                  next_pos      = 4'h0;
                  next_rx_state = (line_low && run_inc == frame_len) ? ubes_pkg::RX_BREAK : ubes_pkg::RX_IDLE;
               end
            end
         end
         ubes_pkg::RX_BREAK: begin
            // A frame of all zeros must outlast the raised threshold
            if (sample) begin
               next_cyc     = '0;
               next_low_run = run_inc;
               if (!line_low) begin
                  next_rx_state = ubes_pkg::RX_IDLE;
               end else if (run_inc == threshold) begin
                  break_seen    = 1'b1;
                  next_rx_state = ubes_pkg::RX_HOLD;
               end
            end
         end
         ubes_pkg::RX_HOLD: begin
            next_cyc = '0;
            next_pos = 4'h0;
            if (!line_low) begin
               next_rx_state = ubes_pkg::RX_IDLE;
            end
         end
         default: begin
            next_rx_state = ubes_pkg::RX_IDLE;
         end
      endcase
      next_full    = char_done & ~lin_break_detect_enable;
      next_framing = char_done & next_stop_low & ~lin_break_detect_enable;
      next_idle    = idle_seen & (~receiver_standby_i | idle_on_wake_select);
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rx_state               <= ubes_pkg::RX_IDLE;
         cyc                    <= '0;
         pos                    <= 4'h0;
         low_run                <= 4'h0;
         stop_low               <= 1'b0;
         active                 <= ubes_pkg::RESET_FLAG;
         receiver_active_flag_o <= 1'b0;
         framing_error_flag_o   <= 1'b0;
         receive_buffer_full_o  <= 1'b0;
         idle_detected_o        <= 1'b0;
      end else if (ce_i) begin
         rx_state               <= next_rx_state;
         cyc                    <= next_cyc;
         pos                    <= next_pos;
         low_run                <= next_low_run;
         stop_low               <= next_stop_low;
         active                 <= next_active;
         receiver_active_flag_o <= next_active;
         framing_error_flag_o   <= next_framing;
         receive_buffer_full_o  <= next_full;
         idle_detected_o        <= next_idle;
      end
   end

   // ==========================================================
   // Registers; a hardware set in the clearing cycle wins
   always_comb begin
      wr_status   = wr_i && (addr_i == ubes_pkg::ADDR_STATUS_TWO);
      wr_event    = wr_i && (addr_i == ubes_pkg::ADDR_EVENT);
      status_view = 8'h00;
      status_view[ubes_pkg::BIT_BREAK]      = break_flag;
      status_view[ubes_pkg::BIT_EDGE]       = edge_flag;
      status_view[ubes_pkg::BIT_RESERVED]   = 1'b0;
      status_view[ubes_pkg::BIT_INVERT]     = receive_invert;
      status_view[ubes_pkg::BIT_IDLE_WAKE]  = idle_on_wake_select;
      status_view[ubes_pkg::BIT_LONG_BREAK] = long_break_select;
      status_view[ubes_pkg::BIT_LIN]        = lin_break_detect_enable;
      status_view[ubes_pkg::BIT_ACTIVE]     = active;
      event_view = 8'h00;
      event_view[ubes_pkg::BIT_BREAK]   = break_flag;
      event_view[ubes_pkg::BIT_EDGE]    = edge_flag;
      event_view[ubes_pkg::EVT_FRAMING] = framing_sticky;
      event_view[ubes_pkg::EVT_FULL]    = full_sticky;
      event_view[ubes_pkg::EVT_IDLE]    = idle_sticky;

      next_break_flag = (break_seen & lin_break_detect_enable)
                      | (break_flag & ~((wr_status | wr_event) & wdata_i[ubes_pkg::BIT_BREAK]));
      next_edge_flag  = edge_evt
                      | (edge_flag & ~((wr_status | wr_event) & wdata_i[ubes_pkg::BIT_EDGE]));
      next_framing_sticky = next_framing | (framing_sticky & ~(wr_event & wdata_i[ubes_pkg::EVT_FRAMING]));
      next_full_sticky    = next_full | (full_sticky & ~(wr_event & wdata_i[ubes_pkg::EVT_FULL]));
      next_idle_sticky    = next_idle | (idle_sticky & ~(wr_event & wdata_i[ubes_pkg::EVT_IDLE]));

      next_receive_invert          = wr_status ? wdata_i[ubes_pkg::BIT_INVERT] : receive_invert;
      next_idle_on_wake_select     = wr_status ? wdata_i[ubes_pkg::BIT_IDLE_WAKE] : idle_on_wake_select;
      next_long_break_select       = wr_status ? wdata_i[ubes_pkg::BIT_LONG_BREAK] : long_break_select;
      next_lin_break_detect_enable = wr_status ? wdata_i[ubes_pkg::BIT_LIN] : lin_break_detect_enable;

      next_control = control;
      if (wr_i && addr_i == ubes_pkg::ADDR_CONTROL) begin
         next_control = 8'h00;
         next_control[ubes_pkg::CTL_NINE_BITS] = wdata_i[ubes_pkg::CTL_NINE_BITS];
         next_control[ubes_pkg::CTL_TWO_STOP]  = wdata_i[ubes_pkg::CTL_TWO_STOP];
      end
      next_send_break = wr_i && (addr_i == ubes_pkg::ADDR_CONTROL) && wdata_i[ubes_pkg::CTL_SEND_BREAK];
      next_mask = (wr_i && addr_i == ubes_pkg::ADDR_MASK) ? wdata_i : mask;

      next_rdata = 8'h00;
      if (rd_i) begin
         case (addr_i)
            ubes_pkg::ADDR_STATUS_TWO: next_rdata = status_view;
            ubes_pkg::ADDR_CONTROL:    next_rdata = control | {5'h00, tx_busy, 2'h0};
            ubes_pkg::ADDR_EVENT:      next_rdata = event_view;
            ubes_pkg::ADDR_MASK:       next_rdata = mask;
            default:                   next_rdata = 8'h00;
         endcase
      end
      next_irq = 1'b0;
      next_irq = |({next_break_flag, next_edge_flag, 3'h0, next_idle_sticky,
                    next_full_sticky, next_framing_sticky} & next_mask);
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         break_flag              <= ubes_pkg::RESET_FLAG;
         edge_flag               <= ubes_pkg::RESET_FLAG;
         receive_invert          <= ubes_pkg::RESET_FLAG;
         idle_on_wake_select     <= ubes_pkg::RESET_FLAG;
         long_break_select       <= ubes_pkg::RESET_FLAG;
         lin_break_detect_enable <= ubes_pkg::RESET_FLAG;
         framing_sticky          <= ubes_pkg::RESET_FLAG;
         full_sticky             <= ubes_pkg::RESET_FLAG;
         idle_sticky             <= ubes_pkg::RESET_FLAG;
         control                 <= ubes_pkg::RESET_CONTROL;
         mask                    <= ubes_pkg::RESET_MASK;
         send_break              <= 1'b0;
         rdata_o                 <= 8'h00;
         irq_o                   <= 1'b0;
         txd_o                   <= 1'b1;
      end else if (ce_i) begin
         break_flag              <= next_break_flag;
         edge_flag               <= next_edge_flag;
         receive_invert          <= next_receive_invert;
         idle_on_wake_select     <= next_idle_on_wake_select;
         long_break_select       <= next_long_break_select;
         lin_break_detect_enable <= next_lin_break_detect_enable;
         framing_sticky          <= next_framing_sticky;
         full_sticky             <= next_full_sticky;
         idle_sticky             <= next_idle_sticky;
         control                 <= next_control;
         mask                    <= next_mask;
         send_break              <= next_send_break;
         rdata_o                 <= next_rdata;
         irq_o                   <= next_irq;
         txd_o                   <= tx_line;
      end
   end
endmodule
`default_nettype wire

/* File: dv/ubes_remote_node.sv */
`timescale 1ns/1ps
`default_nettype none
module ubes_remote_node #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic clock_i,  // Module clock
   input  wire logic invert_i, // Line sent inverted
   output logic      rxd_o     // Receive pin of the device
);
   logic line = 1'b1;
   assign rxd_o = line ^ invert_i;
   // Start plus lows-1 low bits, then idle long enough for the receiver to settle
   task automatic send(input int lows);
      repeat (lows * BIT_CLKS) @(posedge clock_i) line <= 1'b0;
      repeat (12 * BIT_CLKS) @(posedge clock_i) line <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: dv/ubes_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ubes_top_props #(
   parameter int BIT_CLKS = 16
) (
   input wire logic       clock_i,                // Module clock
   input wire logic       rst_n_i,                // Reset, active low
   input wire logic [3:0] addr_i,                 // Address
   input wire logic [7:0] wdata_i,                // Write data
   input wire logic       wr_i,                   // Write strobe
   input wire logic       rd_i,                   // Read strobe
   input wire logic [7:0] rdata_o,                // Read data
   input wire logic       txd_o,                  // Transmit pin
   input wire logic       receiver_active_flag_o, // Receiver busy
   input wire logic       framing_error_flag_o,   // Framing pulse
   input wire logic       receive_buffer_full_o,  // Character pulse
   input wire logic       irq_o                   // Interrupt
);
   logic       lin_q;
   logic [7:0] mask_q;
   int         low_n;
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         lin_q  <= 1'b0;
         mask_q <= 8'h00;
         low_n  <= 0;
      end else begin
         if (wr_i && addr_i == 4'h0) lin_q <= wdata_i[1];
         if (wr_i && addr_i == 4'h3) mask_q <= wdata_i;
         low_n <= txd_o ? 0 : low_n + 1;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_bit5_zero: assert property (rd_i && addr_i == 4'h0 |=> !rdata_o[5]) else $error("bit 5 nonzero");
   a_active_view: assert property (rd_i && addr_i == 4'h0 |=> rdata_o[0] == $past(receiver_active_flag_o))
      else $error("active bit differs");
   a_read_quiet: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
   a_lin_quiet: assert property (lin_q |-> !framing_error_flag_o && !receive_buffer_full_o)
      else $error("flag set in LIN mode");
   a_fe_with_full: assert property (framing_error_flag_o |-> receive_buffer_full_o) else $error("lone framing");
   a_irq_masked: assert property (mask_q == 8'h00 && !wr_i |=> !irq_o) else $error("irq while masked");
   a_break_start: assert property (wr_i && addr_i == 4'h1 && wdata_i[2] && $past(txd_o) |-> ##3 !txd_o)
      else $error("break late");
   a_break_len: assert property ($rose(txd_o) |-> low_n % BIT_CLKS == 0 && low_n / BIT_CLKS inside {[10:15]})
      else $error("break length wrong");
endmodule
bind ubes_top ubes_top_props #(.BIT_CLKS(BIT_CLKS)) props_u (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .txd_o, .receiver_active_flag_o, .framing_error_flag_o, .receive_buffer_full_o, .irq_o);
`default_nettype wire

/* File: dv/uart_break_edge_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_break_edge_status_tb;
   localparam int BC = 16;
   logic clock_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, stby = 1'b0, inv = 1'b0, ce = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o;
   logic txd_o, rxd, act, fe, full, idle, irq;
   int miscompares = 0, total_checks = 0, fe_n = 0, idle_n = 0;
   always #4 clock_i = ~clock_i;
   always @(posedge clock_i) if (fe === 1'b1) fe_n++;
   always @(posedge clock_i) if (idle === 1'b1) idle_n++;
   ubes_top #(.BIT_CLKS(BC)) dut_u (.clock_i, .rst_n_i, .ce_i(ce), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .rxd_i(rxd), .receiver_standby_i(stby), .txd_o, .receiver_active_flag_o(act), .framing_error_flag_o(fe),
      .receive_buffer_full_o(full), .idle_detected_o(idle), .irq_o(irq));
   ubes_remote_node #(.BIT_CLKS(BC)) node_u (.clock_i, .invert_i(inv), .rxd_o(rxd));
   // ==========================================================
   // Bus and compare
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
      @(posedge clock_i) wr_i <= 1'b0;
   endtask
   task rchk(input string n, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clock_i) {addr_i, rd_i} <= {a, 1'b1};
      @(posedge clock_i) rd_i <= 1'b0;
      #1 chk(n, e, rdata_o & m);
   endtask
   // ==========================================================
   // Scenarios
   task t_regs;
      rchk("reset", 4'h0, 8'hFF, 8'h00);
      wr(4'h0, 8'hEF);
      @(posedge clock_i) ce <= 1'b0;
      wr(4'h0, 8'h00);
      ce <= 1'b1;
      rchk("status rw", 4'h0, 8'hFF, 8'h0E);
      rchk("unmapped", 4'h9, 8'hFF, 8'h00);
      wr(4'h0, 8'h00);
      $display("regs done");
   endtask
   task t_edge;
      wr(4'h3, 8'h40);
      node_u.send(1);
      chk("irq", 8'h01, {7'h0, irq});
      rchk("edge", 4'h0, 8'h40, 8'h40);
      wr(4'h0, 8'h40);
      rchk("edge clr", 4'h0, 8'h40, 8'h00);
      #8 chk("irq clr", 8'h00, {7'h0, irq});
      wr(4'h3, 8'h00);
      $display("edge done");
   endtask
   task t_lin;
      wr(4'h0, 8'h02);
      node_u.send(10);
      rchk("lin 10", 4'h0, 8'h80, 8'h00);
      node_u.send(11);
      rchk("lin 11", 4'h0, 8'h80, 8'h80);
      wr(4'h0, 8'h02);
      rchk("w0 keep", 4'h0, 8'h80, 8'h80);
      wr(4'h0, 8'h82);
      rchk("w1 clr", 4'h0, 8'h80, 8'h00);
      wr(4'h0, 8'h00);
      $display("lin done");
   endtask
   task t_fe;
      int n0;
      n0 = fe_n;
      wr(4'h0, 8'h04);
      stby <= 1'b1;
      node_u.send(10);
      chk("framing", 8'h01, 8'(fe_n - n0));
      chk("no idle", 8'h02, 8'(idle_n));
      rchk("no lin flag", 4'h0, 8'h80, 8'h00);
      $display("framing done");
   endtask
   task t_inv;
      int n0;
      @(posedge clock_i) {inv, stby} <= 2'b10;
      wr(4'h0, 8'h10);
      repeat (40) @(posedge clock_i);
      wr(4'h0, 8'h50);
      n0 = fe_n;
      node_u.send(1);
      rchk("inv edge", 4'h0, 8'h40, 8'h40);
      chk("inv frame", 8'h00, 8'(fe_n - n0));
      @(posedge clock_i) inv <= 1'b0;
      wr(4'h0, 8'h00);
      repeat (40) @(posedge clock_i);
      wr(4'h0, 8'hC0);
      $display("invert done");
   endtask
   task t_tx;
      int n;
      for (int i = 0; i < 8; i++) begin
         wr(4'h0, {5'h0, i[2], 2'h0});
         wr(4'h1, {5'h0, 1'b1, i[1], i[0]});
         n = 0;
         while (txd_o === 1'b1 && n < 20) begin
            @(posedge clock_i) #1 n++;
         end
         n = 0;
         while (txd_o !== 1'b1 && n < 400) begin
            @(posedge clock_i) #1 n++;
         end
         chk("break len", 8'((10 + i[0] + i[1] + 3 * i[2]) * BC), 8'(n));
      end
      wr(4'h0, 8'h00);
      $display("break done");
   endtask
   task results;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_regs;
      t_edge;
      t_lin;
      t_fe;
      t_inv;
      t_tx;
      results;
   end
   initial begin
      #300000;
      miscompares++;
      results;
   end
endmodule
`default_nettype wire
